// ### hdl/afc_defines.vh
// Constants of the host controller for the asynchronous 512 x 9 FIFO
`ifndef AFC_DEFINES_VH
`define AFC_DEFINES_VH

`define AFC_CLK_NS           10
`define AFC_CYC(ns)          ((((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS) < 1 ? 1 : \
                              (((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS))

// Pin timing in ns
`define AFC_WR_PULSE_NS      65
`define AFC_WR_RECOV_NS      15
`define AFC_RD_PULSE_NS      65
`define AFC_RD_RECOV_NS      15
`define AFC_CLR_PULSE_NS     65
`define AFC_CLR_SETUP_NS     45
`define AFC_CLR_RECOV_NS     15
`define AFC_REW_PULSE_NS     65
`define AFC_REW_SETUP_NS     45
`define AFC_REW_RECOV_NS     15
`define AFC_NONEMPTY_RD_NS   10
`define AFC_OUT_HOLD_NS      5

// Register byte offsets
`define AFC_REG_CTRL         8'h00
`define AFC_REG_CMD          8'h04
`define AFC_REG_WDATA        8'h08
`define AFC_REG_RDATA        8'h0C
`define AFC_REG_STATUS       8'h10

// Field positions
`define AFC_CTRL_CHAIN       0
`define AFC_CTRL_HEAD_N      1
`define AFC_CMD_CLEAR        0
`define AFC_CMD_REWIND       1
`define AFC_CMD_READ         2
`define AFC_ST_BUSY          0
`define AFC_ST_EMPTY_N       1
`define AFC_ST_FULL_N        2
`define AFC_ST_CLEARED       3
`define AFC_ST_RD_VALID      4
`define AFC_ST_REFUSED       5

`define AFC_WORD_W           9
`define AFC_CTRL_RST         2'h0

`endif

// ### hdl/afc_host.v
// Host controller that drives the asynchronous FIFO pins under APB orders
//
// Register access over APB and the placing of the registers were decided locally.
`include "afc_defines.vh"

module afc_host (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// FIFO control pins
	output reg         write_strobe_n,
	output reg         read_strobe_n,
	output reg         pointer_clear_n,
	output reg         first_load_or_rewind_n,
	output reg         chain_enable_in_n,
	// FIFO data and flags
	output reg  [8:0]  fifo_din,
	input  wire [8:0]  fifo_dout,
	input  wire        no_room_flag_n,
	input  wire        nothing_left_flag_n
);

	localparam [7:0] WR_PULSE_CYC  = `AFC_CYC(`AFC_WR_PULSE_NS);
	localparam [7:0] WR_RECOV_CYC  = `AFC_CYC(`AFC_WR_RECOV_NS);
	localparam [7:0] RD_PULSE_CYC  = `AFC_CYC(`AFC_RD_PULSE_NS);
	localparam [7:0] RD_RECOV_CYC  = `AFC_CYC(`AFC_RD_RECOV_NS);
	localparam [7:0] CLR_PULSE_CYC = `AFC_CYC(`AFC_CLR_PULSE_NS);
	localparam [7:0] CLR_SETUP_CYC = `AFC_CYC(`AFC_CLR_SETUP_NS);
	localparam [7:0] CLR_RECOV_CYC = `AFC_CYC(`AFC_CLR_RECOV_NS);
	localparam [7:0] REW_PULSE_CYC = `AFC_CYC(`AFC_REW_PULSE_NS);
	localparam [7:0] REW_SETUP_CYC = `AFC_CYC(`AFC_REW_SETUP_NS);
	localparam [7:0] REW_RECOV_CYC = `AFC_CYC(`AFC_REW_RECOV_NS);
	localparam [7:0] NE_RD_CYC     = `AFC_CYC(`AFC_NONEMPTY_RD_NS);
	localparam [7:0] CLR_LOW_CYC   = (CLR_PULSE_CYC > CLR_SETUP_CYC) ?
	                                 CLR_PULSE_CYC : CLR_SETUP_CYC;
	localparam [7:0] REW_LOW_CYC   = (REW_PULSE_CYC > REW_SETUP_CYC) ?
	                                 REW_PULSE_CYC : REW_SETUP_CYC;

	localparam [2:0] ST_IDLE    = 3'h0;
	localparam [2:0] ST_WR_LOW  = 3'h1;
	localparam [2:0] ST_RD_LOW  = 3'h2;
	localparam [2:0] ST_CLR_LOW = 3'h3;
	localparam [2:0] ST_CLR_REC = 3'h4;
	localparam [2:0] ST_REW_LOW = 3'h5;
	localparam [2:0] ST_RECOV   = 3'h6;

	reg [2:0]              state;
	reg [7:0]              cnt;
	reg [7:0]              ne_cnt;
	reg [1:0]              ctrl;
	reg [`AFC_WORD_W-1:0]  wdata;
	reg [`AFC_WORD_W-1:0]  rdata;
	reg                    pend_wr;
	reg                    pend_rd;
	reg                    pend_clr;
	reg                    pend_rew;
	reg                    cleared;
	reg                    rd_valid;
	reg                    refused;

	wire apb_hit = psel & penable & ~pready;
	wire pending = pend_wr | pend_rd | pend_clr | pend_rew;
	wire busy    = (state != ST_IDLE) | pending;
	wire ne_ok   = (ne_cnt >= NE_RD_CYC);
	wire [31:0] status_word = {26'h0, refused, rd_valid, cleared, no_room_flag_n,
	                           nothing_left_flag_n, busy};

	// Empty flag high-time counter, saturating
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ne_cnt <= 8'h00;
		end else if (!nothing_left_flag_n) begin
			ne_cnt <= 8'h00;
		end else if (!ne_ok) begin
			ne_cnt <= ne_cnt + 8'h01;
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata                 <= 32'h0;
			pready                 <= 1'b0;
			pslverr                <= 1'b0;
			write_strobe_n         <= 1'b1;
			read_strobe_n          <= 1'b1;
			pointer_clear_n        <= 1'b1;
			first_load_or_rewind_n <= 1'b1;
			chain_enable_in_n      <= 1'b0;
			fifo_din               <= 9'h000;
			state                  <= ST_IDLE;
			cnt                    <= 8'h00;
			ctrl                   <= `AFC_CTRL_RST;
			wdata                  <= 9'h000;
			rdata                  <= 9'h000;
			pend_wr                <= 1'b0;
			pend_rd                <= 1'b0;
			pend_clr               <= 1'b0;
			pend_rew               <= 1'b0;
			cleared                <= 1'b0;
			rd_valid               <= 1'b0;
			refused                <= 1'b0;
		end else begin
			pready  <= apb_hit;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			// Chain mode parks it high, links then run device to device
			// single device strap
			chain_enable_in_n <= ctrl[`AFC_CTRL_CHAIN];
			if (apb_hit) begin
				case (paddr)
				`AFC_REG_CTRL: begin
					prdata <= {30'h0, ctrl};
					if (pwrite && !busy)
						ctrl <= pwdata[1:0];
					else if (pwrite)
						pslverr <= 1'b1;
				end
				`AFC_REG_CMD: begin
					if (!pwrite) begin
						prdata <= 32'h0;
					end else if (busy) begin
						pslverr <= 1'b1;
					end else begin
						pend_clr <= pwdata[`AFC_CMD_CLEAR];
						pend_rew <= pwdata[`AFC_CMD_REWIND];
						pend_rd  <= pwdata[`AFC_CMD_READ];
					end
				end
				`AFC_REG_WDATA: begin
					prdata <= {23'h0, wdata};
					if (pwrite && !busy) begin
						wdata   <= pwdata[8:0];
						pend_wr <= 1'b1;
					end else if (pwrite) begin
						pslverr <= 1'b1;
					end
				end
				`AFC_REG_RDATA: begin
					prdata <= {23'h0, rdata};
					if (pwrite)
						pslverr <= 1'b1;
				end
				`AFC_REG_STATUS: begin
					prdata <= status_word;
					// Clear first so a refusal in this cycle still sets
					if (pwrite && pwdata[`AFC_ST_REFUSED])
						refused <= 1'b0;
					if (pwrite && pwdata[`AFC_ST_RD_VALID])
						rd_valid <= 1'b0;
				end
				default: begin
					pslverr <= 1'b1;
				end
				endcase
			end

			case (state)
			ST_IDLE: begin
				if (pend_clr) begin
					pend_clr <= 1'b0;
					pointer_clear_n <= 1'b0;
					first_load_or_rewind_n <= ctrl[`AFC_CTRL_CHAIN] ?
					                          ctrl[`AFC_CTRL_HEAD_N] : 1'b1;
					cnt   <= CLR_LOW_CYC - 8'h01;
					state <= ST_CLR_LOW;
				end else if (pend_rew) begin
					pend_rew <= 1'b0;
					if (ctrl[`AFC_CTRL_CHAIN] || !cleared) begin
						refused <= 1'b1;
					end else begin
						first_load_or_rewind_n <= 1'b0;
						cnt   <= REW_LOW_CYC - 8'h01;
						state <= ST_REW_LOW;
					end
				end else if (pend_wr) begin
					pend_wr <= 1'b0;
					// no write before clear or when full
					if (!cleared || !no_room_flag_n) begin
						refused <= 1'b1;
					end else begin
						fifo_din       <= wdata;
						write_strobe_n <= 1'b0;
						cnt   <= WR_PULSE_CYC - 8'h01;
						state <= ST_WR_LOW;
					end
				end else if (pend_rd) begin
					if (!cleared || !nothing_left_flag_n) begin
						pend_rd <= 1'b0;
						refused <= 1'b1;
					end else if (ne_ok) begin
						pend_rd       <= 1'b0;
						read_strobe_n <= 1'b0;
						cnt   <= RD_PULSE_CYC - 8'h01;
						state <= ST_RD_LOW;
					end
				end
			end
			ST_WR_LOW: begin
				if (cnt == 8'h00) begin
					write_strobe_n <= 1'b1;
					cnt   <= WR_RECOV_CYC - 8'h01;
					state <= ST_RECOV;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_RD_LOW: begin
				if (cnt == 8'h00) begin
					// old word still valid at strobe rise
					read_strobe_n <= 1'b1;
					rdata    <= fifo_dout;
					rd_valid <= 1'b1;
					cnt   <= RD_RECOV_CYC - 8'h01;
					state <= ST_RECOV;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_CLR_LOW: begin
				if (cnt == 8'h00) begin
					pointer_clear_n <= 1'b1;
					cnt   <= CLR_RECOV_CYC - 8'h01;
					state <= ST_CLR_REC;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_CLR_REC: begin
				if (cnt == 8'h00) begin
					first_load_or_rewind_n <= 1'b1;
					cleared <= 1'b1;
					state   <= ST_IDLE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_REW_LOW: begin
				if (cnt == 8'h00) begin
					first_load_or_rewind_n <= 1'b1;
					cnt   <= REW_RECOV_CYC - 8'h01;
					state <= ST_RECOV;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_RECOV: begin
				if (cnt == 8'h00)
					state <= ST_IDLE;
				else
					cnt <= cnt - 8'h01;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // afc_host

// ### dv/afc_host_assertions.sv
// Checker of the host controller ports
module afc_chk (
	// Clock, reset and APB
	input logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata, prdata,
	// FIFO pins
	input logic        write_strobe_n, read_strobe_n, pointer_clear_n, first_load_or_rewind_n,
	input logic        chain_enable_in_n, no_room_flag_n, nothing_left_flag_n,
	input logic [8:0]  fifo_din, fifo_dout
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_ans; psel && penable && !pready |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_wr; $fell(write_strobe_n) |-> !write_strobe_n[*7] ##1 write_strobe_n[*2]; endproperty
	property p_rd; $fell(read_strobe_n) |-> !read_strobe_n[*7] ##1 read_strobe_n[*2]; endproperty
	property p_empty; $fell(read_strobe_n) |-> $past(nothing_left_flag_n); endproperty
	property p_full; $fell(write_strobe_n) |-> $past(no_room_flag_n); endproperty
	property p_clr; $fell(pointer_clear_n) |-> !pointer_clear_n[*7] ##1 pointer_clear_n; endproperty
	property p_clr_str;
		$fell(pointer_clear_n) |-> (write_strobe_n && read_strobe_n)[*8] ##1
			(write_strobe_n && read_strobe_n);
	endproperty
	property p_rew;
		$fell(first_load_or_rewind_n) && pointer_clear_n |-> read_strobe_n[*8] ##1 read_strobe_n;
	endproperty
	property p_rew_ch; $fell(first_load_or_rewind_n) && pointer_clear_n |-> !chain_enable_in_n;
	endproperty
	property p_din; !write_strobe_n && !$past(write_strobe_n) |-> $stable(fifo_din); endproperty
	a_ans: assert property (p_ans) else $error("apb answer missing");
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	a_wr: assert property (p_wr) else $error("write strobe shape wrong");
	a_rd: assert property (p_rd) else $error("read strobe shape wrong");
	a_empty: assert property (p_empty) else $error("read started while empty");
	a_full: assert property (p_full) else $error("write started while full");
	a_clr: assert property (p_clr) else $error("clear pulse width wrong");
	a_clr_str: assert property (p_clr_str) else $error("strobe low around clear");
	a_rew: assert property (p_rew) else $error("read strobe low around rewind");
	a_rew_ch: assert property (p_rew_ch) else $error("rewind in chain mode");
	a_din: assert property (p_din) else $error("write data moved in pulse");
	c_wr: cover property ($fell(write_strobe_n));
	c_rew: cover property ($fell(first_load_or_rewind_n) && pointer_clear_n);
	c_err: cover property (pslverr);
endmodule // afc_chk

bind afc_host afc_chk u_chk (.clk_sys, .resetn, .psel, .penable, .pwrite, .pready, .pslverr,
	.paddr, .pwdata, .prdata, .write_strobe_n, .read_strobe_n, .pointer_clear_n,
	.first_load_or_rewind_n, .chain_enable_in_n, .no_room_flag_n, .nothing_left_flag_n,
	.fifo_din, .fifo_dout);

// ### dv/afc_fifo_model.sv
// Behavioural model of the 512 x 9 FIFO device
module afc_fifo_model #(
	// Chain output propagation in ns
	parameter int chain_out_fall_delay = 55,
	parameter int chain_out_rise_delay = 60
) (
	// Strobes and straps
	input  logic       write_strobe_n, read_strobe_n, pointer_clear_n,
	input  logic       first_load_or_rewind_n, chain_enable_in_n,
	// Data and flags
	input  logic [8:0] din,
	output logic [8:0] dout,
	output logic       no_room_flag_n, nothing_left_flag_n,
	// Chain link
	output logic       chain_enable_out_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] mem [0:511];
	logic [9:0] wp = 0;
	logic [9:0] rp = 0;
	logic       wr_ok, rd_ok;
	logic       wr_last, rd_last;
	logic       enabled = 1;
	initial begin
		dout = 9'h000;
		chain_enable_out_n = 1'b1;
	end
	assign nothing_left_flag_n = (wp != rp);
	assign no_room_flag_n = !(wp[8:0] == rp[8:0] && wp[9] != rp[9]);
	always @(pointer_clear_n) begin
		if (!pointer_clear_n) begin
			wp = 0;
			rp = 0;
		end else
			enabled = !chain_enable_in_n || !first_load_or_rewind_n;
	end
	always @(negedge first_load_or_rewind_n) if (pointer_clear_n) rp = {wp[9], 9'h000};
	// write judged at fall, stored at rise
	always @(negedge write_strobe_n) begin
		wr_ok = no_room_flag_n && enabled;
		wr_last = wr_ok && wp[8:0] == 9'h1FF;
		// chain out mirrors strobe on last cell
		if (wr_last) chain_enable_out_n <= #(chain_out_fall_delay) 1'b0;
	end
	always @(posedge write_strobe_n) begin
		if (wr_last) chain_enable_out_n <= #(chain_out_rise_delay) 1'b1;
		if (wr_ok) begin
			mem[wp[8:0]] = din;
			wp = wp + 1;
		end
	end
	// word held briefly, then released lines toggle
	always @(negedge read_strobe_n) begin
		rd_ok = nothing_left_flag_n;
		rd_last = rd_ok && rp[8:0] == 9'h1FF;
		dout = rd_ok ? mem[rp[8:0]] : ~dout;
		if (rd_last) chain_enable_out_n <= #(chain_out_fall_delay) 1'b0;
	end
	always @(posedge read_strobe_n) begin
		if (rd_last) chain_enable_out_n <= #(chain_out_rise_delay) 1'b1;
		if (rd_ok) rp = rp + 1;
		#5 dout = ~dout;
	end
endmodule // afc_fifo_model

// ### dv/testbench.sv
// Testbench of the FIFO host controller
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, e;
	logic        wsn, rsn, pcn, flrn, cein, full_n, empty_n, xo;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [8:0]  din, dout;
	int          err_total, checks, xo_cnt;
	afc_host dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .write_strobe_n(wsn), .read_strobe_n(rsn), .pointer_clear_n(pcn),
		.first_load_or_rewind_n(flrn), .chain_enable_in_n(cein), .fifo_din(din),
		.fifo_dout(dout), .no_room_flag_n(full_n), .nothing_left_flag_n(empty_n));
	afc_fifo_model u_fifo (.write_strobe_n(wsn), .read_strobe_n(rsn), .pointer_clear_n(pcn),
		.first_load_or_rewind_n(flrn), .chain_enable_in_n(cein), .din, .dout,
		.no_room_flag_n(full_n), .nothing_left_flag_n(empty_n), .chain_enable_out_n(xo));
	// Chain out pulses seen
	always @(negedge xo) xo_cnt++;
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			err_total++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// Command, then poll status until idle
	task op(input logic [7:0] a, input logic [31:0] d);
		int n;
		apb(1, a, d);
		n = 0;
		do begin
			apb(0, 8'h10, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 60);
		chk(q[0], 0);
	endtask
	task rd(input logic [8:0] x);
		op(8'h04, 32'h4);
		apb(0, 8'h0C, 0);
		chk(q, {23'h0, x});
	endtask
	task print_verdict;
		$display("errors=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#600000;
		err_total++;
		print_verdict;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, resetn, err_total, checks, xo_cnt} = 0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1;
		apb(0, 8'h00, 0);
		chk(q, 0);
		op(8'h08, 32'h55);
		chk(q & 32'h28, 32'h20);
		apb(1, 8'h10, 32'h30);
		op(8'h04, 32'h1);
		chk(q & 32'h2A, 32'h08);
		op(8'h04, 32'h4);
		chk(q & 32'h20, 32'h20);
		apb(1, 8'h10, 32'h30);
		for (int i = 0; i < 512; i++) op(8'h08, i);
		chk(q & 32'h06, 32'h02);
		chk(xo_cnt, 1);
		op(8'h08, 32'h1FF);
		chk(q & 32'h20, 32'h20);
		apb(1, 8'h10, 32'h30);
		rd(9'h000);
		op(8'h08, 32'h1AA);
		for (int i = 1; i < 512; i++) rd(i[8:0]);
		chk(xo_cnt, 2);
		rd(9'h1AA);
		op(8'h04, 32'h1);
		for (int i = 0; i < 3; i++) op(8'h08, 32'h100 + i);
		rd(9'h100);
		op(8'h04, 32'h2);
		rd(9'h100);
		rd(9'h101);
		apb(1, 8'h00, 32'h1);
		op(8'h04, 32'h2);
		chk(q & 32'h20, 32'h20);
		apb(1, 8'h10, 32'h30);
		// Chain head clear, then a later member that waits for its turn
		op(8'h04, 32'h1);
		op(8'h08, 32'h77);
		chk(q & 32'h02, 32'h02);
		apb(1, 8'h00, 32'h3);
		op(8'h04, 32'h1);
		op(8'h08, 32'h78);
		chk(q & 32'h02, 32'h00);
		apb(1, 8'h00, 32'h0);
		apb(0, 8'h40, 0);
		chk(q, 0);
		chk(e, 1);
		apb(1, 8'h0C, 32'h5);
		chk(e, 1);
		print_verdict;
	end
endmodule // testbench
